// file: core/mfi_ctrl.v
`timescale 1ns/1ps
`include "mfi_regs.vh"
module mfi_ctrl (
  // Clock and reset
  input  wire        clock_in,
  input  wire        srst_in,
  // Source events, one-cycle pulses
  input  wire        bus_timeout_ovf_in,
  input  wire        nvm_write_end_in,
  input  wire        low_supply_det_in,
  input  wire [1:0]  timer_period_match_in,
  input  wire [1:0]  timer_cmp_match_in,
  // Serial port status conditions, levels owned by the port
  input  wire [5:0]  serial_port_status_in,
  // Software flag writes: set mask, clear mask over source vector
  input  wire [7:0]  flag_set_in,
  input  wire [7:0]  flag_clr_in,
  // Software enable writes
  input  wire        enable_wr_in,
  input  wire        global_irq_enable_in,
  input  wire [3:0]  group_irq_enable_in,
  input  wire        bus_timeout_enable_in,
  input  wire        serial_port_irq_enable_in,
  input  wire        nvm_write_done_enable_in,
  input  wire        low_supply_enable_in,
  input  wire [1:0]  timer_period_match_enable_in,
  input  wire [1:0]  timer_cmp_match_enable_in,
  // Program sequencer
  input  wire        stack_full_in,
  input  wire        accept_in,
  input  wire        return_from_interrupt_in,
  input  wire        plain_return_in,
  input  wire        low_power_in,
  // Requests to sequencer
  output wire        vector_req_out,
  output reg  [1:0]  vector_group_out,
  output wire        push_pc_out,
  output wire        wake_out,
  // State view
  output wire        global_irq_enable_out,
  output wire [3:0]  group_irq_flag_out,
  output wire        bus_timeout_flag_out,
  output wire        nvm_write_done_flag_out,
  output wire        low_supply_flag_out,
  output wire [1:0]  timer_period_match_flag_out,
  output wire [1:0]  timer_cmp_match_flag_out
);
  reg        global_irq_enable_r;
  reg        global_irq_enable_nxt;
  reg [3:0]  group_irq_enable_r;
  reg [3:0]  group_irq_enable_nxt;
  reg [3:0]  group_irq_flag_r;
  reg [3:0]  group_irq_flag_nxt;
  reg [7:0]  src_flag_r;
  reg [7:0]  src_flag_nxt;
  reg [7:0]  src_en_r;
  reg [7:0]  src_en_nxt;
  reg [7:0]  src_en_wr;
  reg [7:0]  src_evt;
  reg        serial_any_r;
  reg [1:0]  grp_sel;
  reg [1:0]  vector_group_nxt;
  wire       serial_any;
  wire [7:0] src_req;
  wire [3:0] grp_hit;
  wire [3:0] grp_src_req;
  wire [3:0] grp_ready;
  wire [3:0] grp_served;
  wire       wake_rise;
  integer    m;

  // Group number of a source from the packed map
  function [1:0] grp_of;
    input [2:0] idx;
    reg [15:0] map;
    begin
      map    = `MFI_GRP_MAP;
      grp_of = map[{idx, 1'b0} +: 2];
    end
  endfunction

  // Member mask of one group, over the source vector
  function [7:0] grp_members;
    input [1:0] grp;
    integer j;
    begin
      grp_members = 8'h00;
      for (j = 0; j < `MFI_NSRC; j = j + 1) begin
        if (grp_of(j[2:0]) == grp) begin
          grp_members[j] = 1'b1;
        end
      end
    end
  endfunction

  // Serial port flags stay with the port, only their OR is seen
  assign serial_any = |serial_port_status_in;

  // Event vector in source order
  always @* begin
    src_evt                    = 8'h00;
    src_evt[`MFI_SRC_TMO]      = bus_timeout_ovf_in;
    src_evt[`MFI_SRC_UART]     = serial_any & ~serial_any_r;
    src_evt[`MFI_SRC_NVM]      = nvm_write_end_in;
    src_evt[`MFI_SRC_LVD]      = low_supply_det_in;
    src_evt[`MFI_SRC_TMR0]     = timer_period_match_in[0];
    src_evt[`MFI_SRC_TMR0 + 1] = timer_cmp_match_in[0];
    src_evt[`MFI_SRC_TMR0 + 2] = timer_period_match_in[1];
    src_evt[`MFI_SRC_TMR0 + 3] = timer_cmp_match_in[1];
  end

  // Enable image as software writes it
  always @* begin
    src_en_wr                    = `MFI_RST_FLAGS;
    src_en_wr[`MFI_SRC_TMO]      = bus_timeout_enable_in;
    src_en_wr[`MFI_SRC_UART]     = serial_port_irq_enable_in;
    src_en_wr[`MFI_SRC_NVM]      = nvm_write_done_enable_in;
    src_en_wr[`MFI_SRC_LVD]      = low_supply_enable_in;
    src_en_wr[`MFI_SRC_TMR0]     = timer_period_match_enable_in[0];
    src_en_wr[`MFI_SRC_TMR0 + 1] = timer_cmp_match_enable_in[0];
    src_en_wr[`MFI_SRC_TMR0 + 2] = timer_period_match_enable_in[1];
    src_en_wr[`MFI_SRC_TMR0 + 3] = timer_cmp_match_enable_in[1];
  end

  // Source and group enables load together on a write strobe
  always @* begin
    if (enable_wr_in) begin
      src_en_nxt           = src_en_wr;
      group_irq_enable_nxt = group_irq_enable_in;
    end else begin
      src_en_nxt           = src_en_r;
      group_irq_enable_nxt = group_irq_enable_r;
    end
  end

  // Source flags: hardware set wins over software clear; service leaves them
  always @* begin
    src_flag_nxt = (src_flag_r & ~flag_clr_in) | flag_set_in | src_evt;
    src_flag_nxt[`MFI_SRC_UART] = serial_any;
  end

  // Each source gated by its own enable
  assign src_req = src_flag_r & src_en_r;

  // Per group: new member event, enabled member pending, ready, served
  genvar g;
  generate
    for (g = 0; g < `MFI_NGRP; g = g + 1) begin : grp_gen
      localparam [1:0] GID = g;

      assign grp_hit[g]     = |(src_evt & grp_members(GID));
      assign grp_src_req[g] = |(src_req & grp_members(GID));
      assign grp_ready[g]   = group_irq_flag_r[g] & group_irq_enable_r[g] & grp_src_req[g];
      assign grp_served[g]  = push_pc_out & (grp_sel == GID);
    end
  endgenerate

  // Group flags: set by member events, cleared only by service
  always @* begin
    group_irq_flag_nxt = group_irq_flag_r | grp_hit;
    for (m = 0; m < `MFI_NGRP; m = m + 1) begin
      // A new event in the served group keeps it pending
      if (grp_served[m] && !grp_hit[m]) begin
        group_irq_flag_nxt[m] = 1'b0;
      end
    end
  end

  // Lowest group wins when several are ready
  always @* begin
    case (grp_ready)
      4'h0:    grp_sel = 2'h0;
      4'h1:    grp_sel = 2'h0;
      4'h2:    grp_sel = 2'h1;
      4'h3:    grp_sel = 2'h0;
      4'h4:    grp_sel = 2'h2;
      4'h5:    grp_sel = 2'h0;
      4'h6:    grp_sel = 2'h1;
      4'h7:    grp_sel = 2'h0;
      4'h8:    grp_sel = 2'h3;
      4'h9:    grp_sel = 2'h0;
      4'hA:    grp_sel = 2'h1;
      4'hB:    grp_sel = 2'h0;
      4'hC:    grp_sel = 2'h2;
      4'hD:    grp_sel = 2'h0;
      4'hE:    grp_sel = 2'h1;
      4'hF:    grp_sel = 2'h0;
      default: grp_sel = 2'h0;
    endcase
  end

  // Full stack blocks the call; flags wait for a free level
  assign vector_req_out = global_irq_enable_r & (|grp_ready) & ~stack_full_in;

  // Only the program counter goes on the stack
  assign push_pc_out = vector_req_out & accept_in;

  // Service beats everything else in the same cycle
  always @* begin
    global_irq_enable_nxt = global_irq_enable_r;
    if (push_pc_out) begin
      global_irq_enable_nxt = 1'b0;
    end else if (return_from_interrupt_in) begin
      global_irq_enable_nxt = 1'b1;
    end else if (enable_wr_in) begin
      global_irq_enable_nxt = global_irq_enable_in;
    end else if (plain_return_in) begin
      // Plain return leaves the global enable alone
      global_irq_enable_nxt = global_irq_enable_r;
    end
  end

  // Group number is shown one cycle after the decision
  always @* begin
    vector_group_nxt = grp_sel;
  end

  always @(posedge clock_in) begin
    if (srst_in) begin
      global_irq_enable_r <= `MFI_RST_GIE;
    end else begin
      global_irq_enable_r <= global_irq_enable_nxt;
    end
  end

  always @(posedge clock_in) begin
    if (srst_in) begin
      group_irq_enable_r <= `MFI_RST_GEN;
      src_en_r           <= `MFI_RST_FLAGS;
    end else begin
      group_irq_enable_r <= group_irq_enable_nxt;
      src_en_r           <= src_en_nxt;
    end
  end

  always @(posedge clock_in) begin
    if (srst_in) begin
      src_flag_r <= `MFI_RST_FLAGS;
    end else begin
      src_flag_r <= src_flag_nxt;
    end
  end

  always @(posedge clock_in) begin
    if (srst_in) begin
      group_irq_flag_r <= `MFI_RST_GEN;
    end else begin
      group_irq_flag_r <= group_irq_flag_nxt;
    end
  end

  always @(posedge clock_in) begin
    if (srst_in) begin
      serial_any_r     <= 1'b0;
      vector_group_out <= 2'h0;
    end else begin
      serial_any_r     <= serial_any;
      vector_group_out <= vector_group_nxt;
    end
  end

  mfi_edge u_edge (
    .clock_in (clock_in),
    .srst_in  (srst_in),
    .level_in (src_flag_r),
    .rise_out (wake_rise)
  );

  // Flag preset high before sleep gives no rise, so no wake
  assign wake_out = low_power_in & wake_rise;

  assign global_irq_enable_out       = global_irq_enable_r;
  assign group_irq_flag_out          = group_irq_flag_r;
  assign bus_timeout_flag_out        = src_flag_r[`MFI_SRC_TMO];
  assign nvm_write_done_flag_out     = src_flag_r[`MFI_SRC_NVM];
  assign low_supply_flag_out         = src_flag_r[`MFI_SRC_LVD];
  assign timer_period_match_flag_out = {src_flag_r[`MFI_SRC_TMR0 + 2], src_flag_r[`MFI_SRC_TMR0]};
  assign timer_cmp_match_flag_out    = {src_flag_r[`MFI_SRC_TMR0 + 3], src_flag_r[`MFI_SRC_TMR0 + 1]};
endmodule

// file: core/mfi_regs.vh
`ifndef MFI_REGS_VH
`define MFI_REGS_VH
// Group count and timer count
`define MFI_NGRP        4
`define MFI_NTMR        2
// Source vector positions
`define MFI_SRC_TMO     0
`define MFI_SRC_UART    1
`define MFI_SRC_NVM     2
`define MFI_SRC_LVD     3
`define MFI_SRC_TMR0    4
`define MFI_NSRC        8
// Group membership of each source, two bits per source
`define MFI_GRP_MAP     16'hFA50
// Reset values and stack depth
`define MFI_RST_GIE     1'b0
`define MFI_RST_GEN     4'h0
`define MFI_RST_FLAGS   8'h00
`define MFI_STACK_DEPTH 4'h8
`endif

// file: core/mfi_edge.v
`timescale 1ns/1ps
// Rising edge finder for request flags, used for wake-up
module mfi_edge (
  // Clock and reset
  input  wire       clock_in,
  input  wire       srst_in,
  // Flags
  input  wire [7:0] level_in,
  output wire       rise_out
);
  reg [7:0] prev_r;

  always @(posedge clock_in) begin
    if (srst_in) begin
      prev_r <= 8'h00;
    end else begin
      prev_r <= level_in;
    end
  end

  // Enables play no part here
  assign rise_out = |(level_in & ~prev_r);
endmodule

// file: bench/mfi_seq_model.sv
`timescale 1ns/1ps
// Sequencer and return stack as the controller sees them
module mfi_seq_model #(parameter int DEPTH = 2) (
  // Clock and reset
  input  wire logic clock_in,
  input  wire logic srst_in,
  // Controller side
  input  wire logic vector_req_in,
  input  wire logic ret_in,
  output logic      accept_out,
  output logic      stack_full_out,
  // Bench control
  input  wire logic stall_in
);
  int level_r;
  // Vector taken the cycle it is offered unless stalled
  assign accept_out = vector_req_in & ~stall_in;
  // Service code makes no calls, so one level per vector
  assign stack_full_out = (level_r >= DEPTH);
  always @(posedge clock_in) begin
    if (srst_in) level_r <= 0;
    else level_r <= level_r + int'(accept_out) - int'(ret_in);
  end
endmodule

// file: bench/mfi_ctrl_monitor.sv
`timescale 1ns/1ps
module mfi_ctrl_monitor (
  input wire logic       clock_in, srst_in, bus_timeout_ovf_in, low_supply_det_in,
  input wire logic [1:0] timer_period_match_in, timer_period_match_flag_out,
  input wire logic [7:0] flag_clr_in,
  input wire logic       enable_wr_in, stack_full_in, return_from_interrupt_in,
  input wire logic       plain_return_in, low_power_in, vector_req_out, push_pc_out,
  input wire logic       wake_out, global_irq_enable_out, bus_timeout_flag_out,
  input wire logic       low_supply_flag_out,
  input wire logic [3:0] group_irq_flag_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);
  sequence s_served;
    ##1 !global_irq_enable_out;
  endsequence
  a_tmo_set: assert property (bus_timeout_ovf_in |=> bus_timeout_flag_out
    && group_irq_flag_out[0]) else $error("time-out flag not set");
  a_lvd_set: assert property (low_supply_det_in |=> low_supply_flag_out
    && group_irq_flag_out[1]) else $error("low supply flag not set");
  a_tmr_set: assert property (timer_period_match_in[1] |=>
    timer_period_match_flag_out[1] && group_irq_flag_out[3]) else $error("timer flag not set");
  a_stack_block: assert property (stack_full_in |-> !vector_req_out)
    else $error("vector with full stack");
  a_vec_cause: assert property (vector_req_out |-> global_irq_enable_out
    && group_irq_flag_out != 4'h0) else $error("vector without cause");
  a_serve_clr: assert property (push_pc_out |-> s_served)
    else $error("global enable kept after service");
  a_src_keep: assert property (push_pc_out && bus_timeout_flag_out && !flag_clr_in[0]
    |=> bus_timeout_flag_out) else $error("source flag lost on service");
  a_return_from_interrupt_gie: assert property (return_from_interrupt_in && !push_pc_out && !enable_wr_in
    |=> global_irq_enable_out) else $error("return did not enable");
  a_ret_keep: assert property (plain_return_in && !return_from_interrupt_in
    && !enable_wr_in && !global_irq_enable_out |=> !global_irq_enable_out)
    else $error("plain return enabled");
  a_wake_rise: assert property (low_power_in && $rose(bus_timeout_flag_out) |-> wake_out)
    else $error("no wake on flag rise");
  a_grp_hold: assert property (group_irq_flag_out[1] && !push_pc_out
    |=> group_irq_flag_out[1]) else $error("group flag dropped");
endmodule
bind mfi_ctrl mfi_ctrl_monitor u_mfi_ctrl_monitor (.*);

// file: bench/mfi_ctrl_tb.sv
`timescale 1ns/1ps
module mfi_ctrl_tb;
  logic       clock_in, srst_in, bus_timeout_ovf_in, nvm_write_end_in, low_supply_det_in;
  logic [1:0] timer_period_match_in, timer_cmp_match_in, vector_group_out;
  logic [1:0] timer_period_match_enable_in, timer_cmp_match_enable_in;
  logic [1:0] timer_period_match_flag_out, timer_cmp_match_flag_out;
  logic [5:0] serial_port_status_in;
  logic [7:0] flag_set_in, flag_clr_in, ev, src;
  logic [3:0] group_irq_enable_in, group_irq_flag_out;
  logic       enable_wr_in, global_irq_enable_in, bus_timeout_enable_in, stall;
  logic       serial_port_irq_enable_in, nvm_write_done_enable_in, low_supply_enable_in;
  logic       stack_full_in, accept_in, return_from_interrupt_in, plain_return_in;
  logic       low_power_in, vector_req_out, push_pc_out, wake_out, global_irq_enable_out;
  logic       bus_timeout_flag_out, nvm_write_done_flag_out, low_supply_flag_out;
  int         error_cnt = 0;
  int         check_count = 0;
  assign {timer_cmp_match_in[1], timer_period_match_in[1]} = ev[7:6];
  assign {timer_cmp_match_in[0], timer_period_match_in[0]} = ev[5:4];
  assign {low_supply_det_in, nvm_write_end_in, bus_timeout_ovf_in} = {ev[3:2], ev[0]};
  assign src = {timer_cmp_match_flag_out[1], timer_period_match_flag_out[1],
    timer_cmp_match_flag_out[0], timer_period_match_flag_out[0], low_supply_flag_out,
    nvm_write_done_flag_out, 1'b0, bus_timeout_flag_out};
  mfi_ctrl u_mfi_ctrl (.*);
  mfi_seq_model #(.DEPTH(2)) u_mfi_seq_model (.clock_in, .srst_in, .stall_in(stall),
    .vector_req_in(vector_req_out), .ret_in(return_from_interrupt_in | plain_return_in),
    .accept_out(accept_in), .stack_full_out(stack_full_in));
  task automatic cyc(int n = 1);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic rst;
    srst_in = 1;
    cyc(3);
    srst_in = 0;
  endtask
  task automatic set_en(logic g, logic [3:0] grp);
    {global_irq_enable_in, group_irq_enable_in, enable_wr_in} = {g, grp, 1'b1};
    cyc();
    enable_wr_in = 0;
  endtask
  task automatic fire(logic [7:0] v);
    ev = v;
    cyc();
    ev = 8'h00;
  endtask
  task automatic pulse_ret(logic return_from_interrupt);
    {return_from_interrupt_in, plain_return_in} = {return_from_interrupt, !return_from_interrupt};
    cyc();
    {return_from_interrupt_in, plain_return_in} = 2'h0;
  endtask
  // Every source sets its group, and each but the serial port its own flag; software clears sources
  task automatic t_sources;
    logic [7:0] acc = 8'h00;
    rst();
    for (int i = 0; i < 8; i++) if (i != 1) begin
      acc |= 8'h01 << (i / 2);
      fire(8'h01 << i);
      chk("source flag", 8'h01 << i, src);
      chk("group flag", acc, {4'h0, group_irq_flag_out});
      flag_clr_in = 8'hFF;
      cyc();
      flag_clr_in = 8'h00;
    end
    chk("cleared", 8'h00, src);
    for (int k = 0; k < 6; k++) begin
      rst();
      serial_port_status_in = 6'h01 << k;
      cyc();
      chk("serial group", 8'h01, {4'h0, group_irq_flag_out});
      serial_port_status_in = 6'h00;
    end
  endtask
  // Service entry, then both return kinds
  task automatic t_walk;
    rst();
    set_en(1, 4'hF);
    fire(8'h10);
    chk("push", 8'h01, {7'h0, push_pc_out});
    cyc();
    chk("vector group", 8'h02, {6'h0, vector_group_out});
    chk("after service", 8'h10, {global_irq_enable_out, group_irq_flag_out[2], src[5:0]});
    pulse_ret(1);
    chk("return_from_interrupt enable", 8'h01, {7'h0, global_irq_enable_out});
    fire(8'h08);
    cyc();
    pulse_ret(0);
    chk("ret enable", 8'h00, {7'h0, global_irq_enable_out});
  endtask
  // Full stack, with the global enable cleared by the last service, holds the request pending until a return frees a level and sets the enable again
  task automatic t_stack;
    rst();
    set_en(1, 4'hF);
    fire(8'h01);
    set_en(1, 4'hF);
    fire(8'h04);
    set_en(1, 4'hF);
    fire(8'h40);
    chk("blocked", 8'h88, {stack_full_in, vector_req_out, 2'h0, group_irq_flag_out});
    pulse_ret(1);
    chk("unblocked", 8'h01, {7'h0, push_pc_out});
  endtask
  // Enables gate vectoring but never the flags
  task automatic t_gate;
    rst();
    stall = 1;
    set_en(0, 4'hF);
    fire(8'h04);
    chk("no global", 8'h00, {7'h0, vector_req_out});
    set_en(1, 4'hD);
    chk("no group", 8'h02, {vector_req_out, group_irq_flag_out});
    set_en(1, 4'hF);
    chk("enabled", 8'h01, {7'h0, vector_req_out});
    stall = 0;
  endtask
  // Wake on a rising flag, none when the flag was preset
  task automatic t_wake;
    rst();
    low_power_in = 1;
    fire(8'h09);
    chk("wake", 8'h01, {7'h0, wake_out});
    low_power_in = 0;
    flag_set_in = 8'h04;
    cyc();
    flag_set_in = 8'h00;
    low_power_in = 1;
    fire(8'h04);
    chk("preset no wake", 8'h00, {7'h0, wake_out});
    low_power_in = 0;
  endtask
  initial begin
    clock_in = 0;
    forever #5 clock_in = ~clock_in;
  end
  initial begin
    #200000;
    error_cnt++;
    end_sim();
  end
  initial begin
    {srst_in, ev, serial_port_status_in, flag_set_in, flag_clr_in} = {1'b1, 30'h0};
    {enable_wr_in, global_irq_enable_in, group_irq_enable_in, stall} = 7'h0;
    {bus_timeout_enable_in, serial_port_irq_enable_in, nvm_write_done_enable_in} = 3'h7;
    {low_supply_enable_in, timer_period_match_enable_in, timer_cmp_match_enable_in} = 5'h1F;
    {return_from_interrupt_in, plain_return_in, low_power_in} = 3'h0;
    t_sources();
    t_walk();
    t_stack();
    t_gate();
    t_wake();
    end_sim();
  end
endmodule
